// ### shared/sbc_pkg.sv
// Package for the skip and branch program-flow block.
// Assumes an 8-bit core with a word-addressed program counter and
// a 32-bit AXI4-Lite register port.
package sbc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W     = 16;
  localparam int OFFSET_W = 7;

  // ----------------------------------------------------------------
  // Status register flag positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_H = 3'h5;

  // ----------------------------------------------------------------
  // Program counter steps and extra cycles
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_STEP_NEXT       = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP_SKIP_SHORT = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP_SKIP_LONG  = 16'h0003;
  localparam logic [PC_W-1:0] PC_RESET           = 16'h0000;
  localparam logic [1:0]      STALL_NONE         = 2'h0;
  localparam logic [1:0]      STALL_ONE          = 2'h1;
  localparam logic [1:0]      STALL_TWO          = 2'h2;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_COUNT   = 8'h08;
  localparam logic [7:0]  ADDR_PC_LOAD = 8'h0c;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam int          CTRL_ENABLE  = 0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_none                = 4'h0,
    op_skip_reg_bit_clear  = 4'h1,
    op_skip_reg_bit_set    = 4'h2,
    op_skip_io_bit_clear   = 4'h3,
    op_skip_io_bit_set     = 4'h4,
    op_branch_flag_set     = 4'h5,
    op_branch_flag_clear   = 4'h6,
    op_branch_equal        = 4'h7,
    op_branch_not_equal    = 4'h8,
    op_branch_carry_clear  = 4'h9,
    op_branch_same_or_higher = 4'ha,
    op_branch_minus        = 4'hb,
    op_branch_signed_ge    = 4'hc,
    op_branch_half_carry_set = 4'hd
  } op_t;

  typedef enum logic {
    st_idle  = 1'b0,
    st_stall = 1'b1
  } state_t;

  // Decoded instruction with its operands as fetched
  typedef struct packed {
    op_t                 op;
    logic [2:0]          bit_sel;
    logic [OFFSET_W-1:0] offset;
    logic [7:0]          reg_value;
    logic [7:0]          io_value;
    logic                next_two_word;
  } instr_t;

endpackage

// ### verilog/bit_pick.sv
// One-bit selector from a small vector.
// Assumes the select is already in range for the vector width.
`timescale 1ns/1ps
module bit_pick #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]         vec,
  input  wire logic [$clog2(W)-1:0] sel,
  output logic                      bit_out
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Plain indexed pick
  assign bit_out = vec[sel];

endmodule

// ### verilog/skip_branch_control.sv
// Skip and conditional branch control with its program counter.
// Assumes decoded instructions with operands arrive from the decoder,
// and software uses an AXI4-Lite master on the same clock.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module skip_branch_control (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire sbc_pkg::instr_t instr,
  input  wire logic          instr_valid,
  input  wire logic [7:0]    status_flags,
  output logic               instr_ready,
  output logic [15:0]        pc,
  output logic               retire,
  output logic               flag_write_en,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [7:0]    s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sbc_pkg::state_t                 state;
  logic [1:0]                      stall_cnt;
  logic [31:0]                     ctrl;
  logic [31:0]                     taken_count;
  logic [7:0]                      aw_addr;
  logic [31:0]                     w_data;
  logic [3:0]                      w_strb;
  logic                            reg_bit;
  logic                            io_bit;
  logic                            flag_bit;
  logic [2:0]                      flag_sel;
  logic                            take;
  logic                            is_skip;
  logic [1:0]                      next_stall;
  logic [sbc_pkg::PC_W-1:0]        next_pc;
  logic [sbc_pkg::PC_W-1:0]        branch_disp;
  logic                            accept;
  logic                            wr_fire;
  logic [31:0]                     wr_mask;
  logic                            pc_load_hit;

  // Instruction taken this cycle
  assign accept = instr_valid && instr_ready;

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  // Bit pickers for register, I/O and status flag operands
  bit_pick #(.W(8)) u_reg_bit (
    .vec     (instr.reg_value),
    .sel     (instr.bit_sel),
    .bit_out (reg_bit)
  );

  bit_pick #(.W(8)) u_io_bit (
    .vec     (instr.io_value),
    .sel     (instr.bit_sel),
    .bit_out (io_bit)
  );

  bit_pick #(.W(8)) u_flag_bit (
    .vec     (status_flags),
    .sel     (flag_sel),
    .bit_out (flag_bit)
  );

  // Signed word displacement from the offset field
  assign branch_disp = {{(sbc_pkg::PC_W-sbc_pkg::OFFSET_W){instr.offset[sbc_pkg::OFFSET_W-1]}},
                        instr.offset};

  // Flag choice and taken decision per operation
  always_comb begin
    flag_sel = instr.bit_sel;
    take     = 1'b0;
    is_skip  = 1'b0;
    case (instr.op)
      sbc_pkg::op_skip_reg_bit_clear: begin
        take    = !reg_bit;
        is_skip = 1'b1;
      end
      sbc_pkg::op_skip_reg_bit_set: begin
        take    = reg_bit;
        is_skip = 1'b1;
      end
      sbc_pkg::op_skip_io_bit_clear: begin
        take    = !io_bit;
        is_skip = 1'b1;
      end
      sbc_pkg::op_skip_io_bit_set: begin
        take    = io_bit;
        is_skip = 1'b1;
      end
      sbc_pkg::op_branch_flag_set: begin
        take = flag_bit;
      end
      sbc_pkg::op_branch_flag_clear: begin
        take = !flag_bit;
      end
      sbc_pkg::op_branch_equal: begin
        flag_sel = sbc_pkg::FLAG_Z;
        take     = flag_bit;
      end
      sbc_pkg::op_branch_not_equal: begin
        flag_sel = sbc_pkg::FLAG_Z;
        take     = !flag_bit;
      end
      sbc_pkg::op_branch_carry_clear: begin
        flag_sel = sbc_pkg::FLAG_C;
        take     = !flag_bit;
      end
      sbc_pkg::op_branch_same_or_higher: begin
        flag_sel = sbc_pkg::FLAG_C;
        take     = !flag_bit;
      end
      sbc_pkg::op_branch_minus: begin
        flag_sel = sbc_pkg::FLAG_N;
        take     = flag_bit;
      end
      sbc_pkg::op_branch_signed_ge: begin
        take = !(status_flags[sbc_pkg::FLAG_N] ^ status_flags[sbc_pkg::FLAG_V]);
      end
      sbc_pkg::op_branch_half_carry_set: begin
        flag_sel = sbc_pkg::FLAG_H;
        take     = flag_bit;
      end
      default: begin
        take = 1'b0;
      end
    endcase
  end

  // Next program counter and extra cycles
  always_comb begin
    next_pc    = pc + sbc_pkg::PC_STEP_NEXT;
    next_stall = sbc_pkg::STALL_NONE;
    if (take && is_skip) begin
      if (instr.next_two_word) begin
        next_pc    = pc + sbc_pkg::PC_STEP_SKIP_LONG;
        next_stall = sbc_pkg::STALL_TWO;
      end else begin
        next_pc    = pc + sbc_pkg::PC_STEP_SKIP_SHORT;
        next_stall = sbc_pkg::STALL_ONE;
      end
    end else if (take) begin
      next_pc    = pc + branch_disp + sbc_pkg::PC_STEP_NEXT;
      next_stall = sbc_pkg::STALL_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Issue state, stall count, ready and retire pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= sbc_pkg::st_idle;
      stall_cnt   <= sbc_pkg::STALL_NONE;
      instr_ready <= 1'b0;
      retire      <= 1'b0;
    end else begin
      retire <= 1'b0;
      case (state)
        sbc_pkg::st_idle: begin
          instr_ready <= ctrl[sbc_pkg::CTRL_ENABLE];
          if (accept) begin
            if (next_stall == sbc_pkg::STALL_NONE) begin
              retire <= 1'b1;
            end else begin
              state       <= sbc_pkg::st_stall;
              stall_cnt   <= next_stall;
              instr_ready <= 1'b0;
            end
          end
        end
        sbc_pkg::st_stall: begin
          stall_cnt <= stall_cnt - 2'h1;
          if (stall_cnt == sbc_pkg::STALL_ONE) begin
            state       <= sbc_pkg::st_idle;
            retire      <= 1'b1;
            instr_ready <= ctrl[sbc_pkg::CTRL_ENABLE];
          end
        end
        default: begin
          state <= sbc_pkg::st_idle;
        end
      endcase
    end
  end

  // Program counter: instruction update wins over a software load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc <= sbc_pkg::PC_RESET;
    end else if (accept) begin
      pc <= next_pc;
    end else if (pc_load_hit) begin
      pc <= (pc & ~wr_mask[15:0]) | (w_data[15:0] & wr_mask[15:0]);
    end
  end

  // Status flags are never written by this block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_write_en <= 1'b0;
    end else begin
      flag_write_en <= 1'b0;
    end
  end

  // Count of taken branches and skips
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_count <= 32'h0000_0000;
    end else if (accept && take) begin
      taken_count <= taken_count + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Write commits once address and data are both held
  assign wr_fire     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_mask     = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign pc_load_hit = wr_fire && ({aw_addr[7:2], 2'h0} == sbc_pkg::ADDR_PC_LOAD);

  // Address and data capture, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sbc_pkg::RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if ({aw_addr[7:2], 2'h0} == sbc_pkg::ADDR_CTRL) begin
          s_axi_bresp <= sbc_pkg::RESP_OKAY;
        end else if ({aw_addr[7:2], 2'h0} == sbc_pkg::ADDR_STATUS) begin
          s_axi_bresp <= sbc_pkg::RESP_OKAY;
        end else if ({aw_addr[7:2], 2'h0} == sbc_pkg::ADDR_COUNT) begin
          s_axi_bresp <= sbc_pkg::RESP_OKAY;
        end else if ({aw_addr[7:2], 2'h0} == sbc_pkg::ADDR_PC_LOAD) begin
          s_axi_bresp <= sbc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= sbc_pkg::RESP_DECERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control register with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= sbc_pkg::CTRL_RESET;
    end else if (wr_fire && ({aw_addr[7:2], 2'h0} == sbc_pkg::ADDR_CTRL)) begin
      ctrl <= (ctrl & ~wr_mask) | (w_data & wr_mask & sbc_pkg::CTRL_RESET);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Read decode and single-beat answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sbc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= sbc_pkg::RESP_OKAY;
        if ({s_axi_araddr[7:2], 2'h0} == sbc_pkg::ADDR_CTRL) begin
          s_axi_rdata <= ctrl;
        end else if ({s_axi_araddr[7:2], 2'h0} == sbc_pkg::ADDR_STATUS) begin
          s_axi_rdata <= {15'h0, (state == sbc_pkg::st_stall), pc};
        end else if ({s_axi_araddr[7:2], 2'h0} == sbc_pkg::ADDR_COUNT) begin
          s_axi_rdata <= taken_count;
        end else if ({s_axi_araddr[7:2], 2'h0} == sbc_pkg::ADDR_PC_LOAD) begin
          s_axi_rdata <= {16'h0000, pc};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= sbc_pkg::RESP_DECERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_skip_reg_clear;
    accept && instr.op == sbc_pkg::op_skip_reg_bit_clear && !reg_bit && !instr.next_two_word
      |=> pc == $past(pc) + 16'h0002 && !instr_ready ##1 retire;
  endproperty
  a_skip_reg_clear: assert property (p_skip_reg_clear)
    else $error("reg bit clear skip did not step pc by two");

  property p_skip_reg_set_no_skip;
    accept && instr.op == sbc_pkg::op_skip_reg_bit_set && !reg_bit
      |=> pc == $past(pc) + 16'h0001 && retire;
  endproperty
  a_skip_reg_set_no_skip: assert property (p_skip_reg_set_no_skip)
    else $error("reg bit set skip with bit low did not continue");

  property p_skip_io_clear_long;
    accept && instr.op == sbc_pkg::op_skip_io_bit_clear && !io_bit && instr.next_two_word
      |=> pc == $past(pc) + 16'h0003 ##0 !retire [*2] ##1 retire;
  endproperty
  a_skip_io_clear_long: assert property (p_skip_io_clear_long)
    else $error("io bit clear skip over long instruction wrong");

  property p_skip_io_set;
    accept && instr.op == sbc_pkg::op_skip_io_bit_set
      |=> retire == !$past(io_bit);
  endproperty
  a_skip_io_set: assert property (p_skip_io_set)
    else $error("io bit set skip decision wrong");

  property p_branch_flag_set_target;
    accept && instr.op == sbc_pkg::op_branch_flag_set && flag_bit
      |=> pc == $past(pc) + $past(branch_disp) + 16'h0001 ##0 !retire ##1 retire;
  endproperty
  a_branch_flag_set_target: assert property (p_branch_flag_set_target)
    else $error("flag set branch target or timing wrong");

  property p_branch_flag_clear_not_taken;
    accept && instr.op == sbc_pkg::op_branch_flag_clear && flag_bit
      |=> pc == $past(pc) + 16'h0001 && retire;
  endproperty
  a_branch_flag_clear_not_taken: assert property (p_branch_flag_clear_not_taken)
    else $error("flag clear branch taken with flag set");

  property p_branch_equal;
    accept && instr.op == sbc_pkg::op_branch_equal
      |=> retire == !$past(status_flags[1]);
  endproperty
  a_branch_equal: assert property (p_branch_equal)
    else $error("equal branch decision wrong");

  property p_branch_signed_ge;
    accept && instr.op == sbc_pkg::op_branch_signed_ge
      |=> retire == ($past(status_flags[2]) ^ $past(status_flags[3]));
  endproperty
  a_branch_signed_ge: assert property (p_branch_signed_ge)
    else $error("signed ge branch decision wrong");

  property p_no_flag_write;
    instr_valid |-> !flag_write_en throughout (##[0:3] 1'b1);
  endproperty
  a_no_flag_write: assert property (p_no_flag_write)
    else $error("status flags written by flow control");

endmodule

// ### bench/tb_skip_branch_control.sv
// Self-checking bench for the skip and branch control block.
// Assumes the block alone under test, a 100 MHz clock and the bench as AXI4-Lite master.
`timescale 1ns/1ps
module tb_skip_branch_control;
  typedef struct {
    logic [15:0] pc;
    int          lat;
    int          t;
    int          kind;
  } exp_t;

  logic            aclk;
  logic            aresetn;
  sbc_pkg::instr_t instr;
  logic            instr_valid;
  logic [7:0]      status_flags;
  logic            instr_ready;
  logic [15:0]     pc;
  logic            retire;
  logic            flag_write_en;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, rd, seed;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0]     model_pc;
  exp_t            exp_q[$];
  int              cyc, miscompares, check_count, taken_count;

  skip_branch_control i_skip_branch_control (.aclk(aclk), .aresetn(aresetn), .instr(instr),
    .instr_valid(instr_valid), .status_flags(status_flags), .instr_ready(instr_ready),
    .pc(pc), .retire(retire), .flag_write_en(flag_write_en), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));

  // ----------------------------------------------------------------
  // Clock, cycle count and shared tasks
  // ----------------------------------------------------------------
  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Steps the feedback register a full word so values are not shifted copies
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 32; k++) begin
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
    return s;
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 0;
    w_ok = 0;
    do begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Offers one instruction, waits for it to be taken and notes the expected outcome
  task automatic run_instr(input sbc_pkg::instr_t x, input logic [7:0] f, input bit keep);
    exp_t e;
    logic hit;
    instr <= x;
    instr_valid <= 1'b1;
    status_flags <= f;
    do @(posedge aclk); while (instr_ready !== 1'b1);
    case (x.op)
      sbc_pkg::op_skip_reg_bit_clear:    hit = !x.reg_value[x.bit_sel];
      sbc_pkg::op_skip_reg_bit_set:      hit = x.reg_value[x.bit_sel];
      sbc_pkg::op_skip_io_bit_clear:     hit = !x.io_value[x.bit_sel];
      sbc_pkg::op_skip_io_bit_set:       hit = x.io_value[x.bit_sel];
      sbc_pkg::op_branch_flag_set:       hit = f[x.bit_sel];
      sbc_pkg::op_branch_flag_clear:     hit = !f[x.bit_sel];
      sbc_pkg::op_branch_equal:          hit = f[sbc_pkg::FLAG_Z];
      sbc_pkg::op_branch_not_equal:      hit = !f[sbc_pkg::FLAG_Z];
      sbc_pkg::op_branch_carry_clear:    hit = !f[sbc_pkg::FLAG_C];
      sbc_pkg::op_branch_same_or_higher: hit = !f[sbc_pkg::FLAG_C];
      sbc_pkg::op_branch_minus:          hit = f[sbc_pkg::FLAG_N];
      sbc_pkg::op_branch_signed_ge:      hit = !(f[sbc_pkg::FLAG_N] ^ f[sbc_pkg::FLAG_V]);
      sbc_pkg::op_branch_half_carry_set: hit = f[sbc_pkg::FLAG_H];
      default:                           hit = 1'b0;
    endcase
    e.kind = (x.op == sbc_pkg::op_none) ? 0 : (x.op <= sbc_pkg::op_skip_io_bit_set) ? 1 :
             (x.op <= sbc_pkg::op_branch_flag_clear) ? 2 : 3;
    e.t = cyc;
    e.lat = !hit ? 1 : (e.kind == 1 && x.next_two_word) ? 3 : 2;
    e.pc = !hit ? model_pc + 16'h1 : (e.kind == 1) ? model_pc + 16'(e.lat) :
           model_pc + {{9{x.offset[6]}}, x.offset} + 16'h1;
    taken_count += int'(hit);
    model_pc = e.pc;
    exp_q.push_back(e);
    if (!keep) begin
      instr_valid <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // ----------------------------------------------------------------
  // Result watcher and watchdog
  // ----------------------------------------------------------------
  always @(posedge aclk) begin : watch
    exp_t e;
    if (retire === 1'b1 && exp_q.size() == 0) begin
      check(32'(retire), 32'h0);
    end else if (retire === 1'b1) begin
      e = exp_q.pop_front();
      case (e.kind)
        1:       check(32'(pc), 32'(e.pc));
        2:       check(32'(pc), 32'(e.pc));
        3:       check(32'(pc), 32'(e.pc));
        default: check(32'(pc), 32'(e.pc));
      endcase
      check(32'(cyc - e.t), 32'(e.lat));
      check(32'(flag_write_en), 32'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sbc_pkg::instr_t x;
    aclk = 0;
    aresetn = 0;
    instr = '0;
    {instr_valid, status_flags, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {cyc, miscompares, check_count, taken_count} = '0;
    model_pc = 16'h0000;
    seed = 32'h0a49;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(sbc_pkg::ADDR_CTRL, rd, rsp);
    check(rd, sbc_pkg::CTRL_RESET);
    axi_rd(8'h10, rd, rsp);
    check({rd[31:2], rsp}, {30'h0, sbc_pkg::RESP_DECERR});
    axi_wr(8'h20, 32'h0000_00ff, rsp);
    check(32'(rsp), 32'(sbc_pkg::RESP_DECERR));
    axi_wr(sbc_pkg::ADDR_PC_LOAD, 32'h0000_fff0, rsp);
    model_pc = 16'hfff0;
    axi_rd(sbc_pkg::ADDR_STATUS, rd, rsp);
    check(rd, {16'h0000, model_pc});
    axi_wr(sbc_pkg::ADDR_CTRL, 32'h0000_0000, rsp);
    repeat (3) @(posedge aclk);
    check(32'(instr_ready), 32'h0);
    axi_wr(sbc_pkg::ADDR_CTRL, 32'h0000_0001, rsp);
    $display("test registers done");
    // Offset extremes, long skip and back-to-back issue
    run_instr('{sbc_pkg::op_branch_flag_set, 3'h7, 7'h40, 8'h00, 8'h00, 1'b0}, 8'h80, 1'b1);
    run_instr('{sbc_pkg::op_branch_equal, 3'h0, 7'h3f, 8'h00, 8'h00, 1'b0}, 8'h02, 1'b1);
    run_instr('{sbc_pkg::op_branch_not_equal, 3'h0, 7'h05, 8'h00, 8'h00, 1'b0}, 8'h02, 1'b1);
    run_instr('{sbc_pkg::op_skip_reg_bit_set, 3'h7, 7'h00, 8'h80, 8'h00, 1'b1}, 8'h00, 1'b1);
    run_instr('{sbc_pkg::op_skip_io_bit_clear, 3'h0, 7'h00, 8'h00, 8'hfe, 1'b0}, 8'h00, 1'b0);
    $display("test directed done");
    for (int k = 0; k < 300; k++) begin
      seed = lfsr(seed);
      x.op = sbc_pkg::op_t'(4'(seed[7:0] % 14));
      x.bit_sel = seed[10:8];
      x.offset = seed[17:11];
      x.reg_value = seed[25:18];
      seed = lfsr(seed);
      x.io_value = seed[7:0];
      x.next_two_word = seed[8];
      run_instr(x, seed[23:16], seed[24]);
    end
    instr_valid <= 1'b0;
    repeat (6) @(posedge aclk);
    check(32'(exp_q.size()), 32'h0);
    $display("test random done");
    axi_rd(sbc_pkg::ADDR_COUNT, rd, rsp);
    check(rd, 32'(taken_count));
    axi_wr(sbc_pkg::ADDR_STATUS, 32'hffff_ffff, rsp);
    check(32'(rsp), 32'(sbc_pkg::RESP_OKAY));
    axi_rd(sbc_pkg::ADDR_STATUS, rd, rsp);
    check(rd, {16'h0000, model_pc});
    $display("test counters done");
    final_report();
  end
endmodule
